// ### rtl/pst_map.svh
// Register offsets, field positions, reset values and setting ranges
`ifndef PST_MAP_SVH
`define PST_MAP_SVH

`define PST_AW              8
`define PST_OFS_CTRL        8'h00
`define PST_OFS_SPD1        8'h04
`define PST_OFS_SPD7        8'h1C
`define PST_OFS_FWD_INT     8'h20
`define PST_OFS_REV_INT     8'h24
`define PST_OFS_FWD_EXT     8'h28
`define PST_OFS_REV_EXT     8'h2C
`define PST_OFS_MOT_SPD     8'h30
`define PST_OFS_MOT_TRQ     8'h34
`define PST_OFS_STATUS      8'h38
`define PST_OFS_SPD_OUT     8'h3C
`define PST_OFS_TRQ_OUT     8'h40

`define PST_MODE_MSB        7
`define PST_MODE_LSB        4
`define PST_ATL_MSB         11
`define PST_ATL_LSB         8
`define PST_MODE_PRESET     4'h3
`define PST_MODE_SW_SPEED   4'h4
`define PST_MODE_SW_POS     4'h5
`define PST_MODE_SW_TRQ     4'h6
`define PST_ATL_ON          4'h1

`define PST_RST_CTRL        16'h0000
`define PST_RST_SPD1        16'h0064
`define PST_RST_SPD2        16'h00C8
`define PST_RST_SPD3        16'h012C
`define PST_RST_SPD4        16'hFF9C
`define PST_RST_SPD5        16'hFF38
`define PST_RST_SPD6        16'hFED4
`define PST_RST_SPD7        16'h01F4
`define PST_RST_INT_TRQ     10'h12C
`define PST_RST_EXT_TRQ     10'h064
`define PST_RST_MOT_SPD     16'h1770
`define PST_RST_MOT_TRQ     10'h12C

`define PST_MAX_SET_SPD     16'h1770
`define PST_MAX_INT_TRQ     10'h190
`define PST_MAX_EXT_TRQ     10'h12C
`define PST_RESP_OKAY       2'h0
`define PST_RESP_SLVERR     2'h2

`endif

// ### rtl/pst_pkg.sv
// Types shared by the preset speed and torque limit block
`include "pst_map.svh"
package pst_pkg;
   typedef enum logic [1:0] {
      PST_LOOP_SPEED = 2'b00,
      PST_LOOP_POS   = 2'b01,
      PST_LOOP_TRQ   = 2'b10,
      PST_LOOP_OTHER = 2'b11
   } pst_loop_t;

   typedef enum logic [1:0] {
      PST_RD_IDLE  = 2'b00,
      PST_RD_FETCH = 2'b01,
      PST_RD_RESP  = 2'b10
   } pst_rd_t;

   typedef struct packed {
      logic             awvalid;
      logic [`PST_AW-1:0] awaddr;
      logic             wvalid;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic             bready;
      logic             arvalid;
      logic [`PST_AW-1:0] araddr;
      logic             rready;
   } pst_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pst_axi_rsp_t;

   typedef struct packed {
      logic speed_select_high_bit_n;
      logic forward_limit_select_n;
      logic reverse_limit_select_n;
   } pst_contact_t;

   typedef struct packed {
      pst_loop_t          loop;
      logic               preset_active;
      logic signed [15:0] speed_ref;
      logic [9:0]         fwd_torque_limit;
      logic [9:0]         rev_torque_limit;
      logic               analog_limit_used;
   } pst_drive_t;

   typedef struct packed {
      logic [15:0]        control_mode_select;
      logic [15:0]        function_option_select;
      logic [9:0]         fwd_int;
      logic [9:0]         rev_int;
      logic [9:0]         fwd_ext;
      logic [9:0]         rev_ext;
      logic [15:0]        mot_spd;
      logic [9:0]         mot_trq;
      logic               aw_have;
      logic [`PST_AW-1:0] aw_addr;
      logic               w_have;
      logic [31:0]        w_data;
      logic [3:0]         w_strb;
      logic               bvalid;
      logic [1:0]         bresp;
      pst_rd_t            rd_st;
      logic [`PST_AW-1:0] rd_addr;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
      logic [2:0]         idx;
      pst_drive_t         drive;
   } pst_state_t;
endpackage : pst_pkg

// ### rtl/pst_speed_mem.sv
// Preset speed table: one write port, two read ports with registered data
`include "pst_map.svh"
module pst_speed_mem #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic                     i_clock,
   input  wire logic                     i_sys_rst,
   // Write port
   input  wire logic                     i_wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
   input  wire logic [W-1:0]             i_wr_data,
   // Read ports
   input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr_a,
   output logic      [W-1:0]             o_rd_data_a,
   input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr_b,
   output logic      [W-1:0]             o_rd_data_b
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0]            rd_a;
      logic [W-1:0]            rd_b;
   } pst_mem_state_t;

   pst_mem_state_t s_r;
   pst_mem_state_t s_nxt;

   // Word 0 stays zero so the all-off combination reads a zero speed
   function automatic pst_mem_state_t pst_mem_rst();
      pst_mem_state_t r;
      r = '0;
      r.mem[1] = W'(`PST_RST_SPD1);
      r.mem[2] = W'(`PST_RST_SPD2);
      r.mem[3] = W'(`PST_RST_SPD3);
      r.mem[4] = W'(`PST_RST_SPD4);
      r.mem[5] = W'(`PST_RST_SPD5);
      r.mem[6] = W'(`PST_RST_SPD6);
      r.mem[7] = W'(`PST_RST_SPD7);
      return r;
   endfunction : pst_mem_rst

   always_comb begin
      s_nxt = s_r;
      if (i_wr_en && (i_wr_addr != '0)) begin
         s_nxt.mem[i_wr_addr] = i_wr_data;
      end
      s_nxt.rd_a = s_r.mem[i_rd_addr_a];
      s_nxt.rd_b = s_r.mem[i_rd_addr_b];
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         s_r <= pst_mem_rst();
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rd_data_a = s_r.rd_a;
   assign o_rd_data_b = s_r.rd_b;
endmodule : pst_speed_mem

// ### rtl/pst_top.sv
// Preset speed selection and torque limit selection behind an AXI4-Lite slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`include "pst_map.svh"

// Summary of operation
// - Control mode 3 takes speed reference from presets chosen by contacts.
// - Speed index: high-bit select is bit 2, forward bit 1, reverse bit 0.
// - All three contacts off in preset mode gives zero speed under speed control.
// - Contacts are active low: low means on.
// - Seven signed presets in rpm, -6000 to 6000, defaults listed, immediate effect.
// - A preset above motor maximum speed in magnitude uses motor maximum.
// - Modes 4, 5, 6: nonzero index selects presets, all off switches mode.
// - Mode 5 with all contacts off switches to pulse train position control.
// - Internal forward and reverse limits always apply, 0 to 400 percent, default 300.
// - Any limit above motor maximum torque is replaced by motor maximum.
// - External limits 0 to 300 percent in 1 percent steps, default 100.
// - Outside modes 3 to 6, forward select on applies forward external limit, off the internal one.
// - Outside modes 3 to 6, reverse select on applies reverse external limit, off the internal one.
// - Analog torque limit applies in speed or position control, never torque.
// - Analog limit uses absolute value, applied both directions.
// - Analog limit enabled only when function option digit two equals 1.
module pst_top
   import pst_pkg::*;
#(
   parameter logic [15:0] MOTOR_MAX_SPEED  = `PST_RST_MOT_SPD,
   parameter logic [9:0]  MOTOR_MAX_TORQUE = `PST_RST_MOT_TRQ
) (
   // Clock and reset
   input  wire logic               i_clock,
   input  wire logic               i_sys_rst,
   // Register bus
   input  wire pst_axi_req_t       i_axi,
   output pst_axi_rsp_t            o_axi,
   // Contact inputs, active low
   input  wire pst_contact_t       i_contact,
   // Analog torque limit in percent of rated, and other-mode status
   input  wire logic signed [15:0] i_analog_torque_limit,
   input  wire logic               i_torque_control_active,
   // Reference to the speed and torque loops
   output pst_drive_t              o_drive
);
   import pst_pkg::*;

   pst_state_t         s_r;
   pst_state_t         s_nxt;
   logic               mem_we;
   logic [2:0]         mem_waddr;
   logic [15:0]        mem_wdata;
   logic [2:0]         rd_b_addr;
   logic [15:0]        spd_a;
   logic [15:0]        spd_b;
   logic [2:0]         idx_now;
   logic [3:0]         mode;
   logic [7:0]         waw;
   logic [31:0]        wold;
   logic [31:0]        wnew;
   logic               wok;
   logic               ana_en;
   logic [9:0]         ana_abs;
   logic [9:0]         fwd_lim;
   logic [9:0]         rev_lim;
   logic               ext_ok;
   logic [7:0]         raw;

   function automatic logic [2:0] pst_index(input pst_contact_t c);
      return {~c.speed_select_high_bit_n, ~c.forward_limit_select_n, ~c.reverse_limit_select_n};
   endfunction : pst_index

   // Unsigned compare: every limit is a magnitude in percent of rated torque
   function automatic logic [9:0] pst_min10(input logic [9:0] a, input logic [9:0] b);
      return (a < b) ? a : b;
   endfunction : pst_min10

   // Saturate a wide value into a limit field; the upper bits are compared too,
   // so an oversized write lands on the range top instead of wrapping
   function automatic logic [9:0] pst_sat10(input logic [15:0] v, input logic [9:0] max);
      return (v > {6'h00, max}) ? max : v[9:0];
   endfunction : pst_sat10

   // Symmetric clamp of a signed speed to plus or minus a magnitude
   function automatic logic [15:0] pst_clamp_spd(input logic [15:0] v, input logic [15:0] lim);
      logic signed [15:0] sv;
      logic signed [15:0] sl;
      sv = signed'(v);
      sl = signed'(lim);
      if (sv > sl) begin
         return lim;
      end else if (sv < -sl) begin
         return 16'(-sl);
      end
      return v;
   endfunction : pst_clamp_spd

   function automatic logic [31:0] pst_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] st);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[8*b +: 8] = n[8*b +: 8];
         end
      end
      return r;
   endfunction : pst_merge

   function automatic pst_state_t pst_state_rst();
      pst_state_t r;
      r = '0;
      r.control_mode_select = `PST_RST_CTRL;
      r.fwd_int             = `PST_RST_INT_TRQ;
      r.rev_int             = `PST_RST_INT_TRQ;
      r.fwd_ext             = `PST_RST_EXT_TRQ;
      r.rev_ext             = `PST_RST_EXT_TRQ;
      r.mot_spd             = MOTOR_MAX_SPEED;
      r.mot_trq             = MOTOR_MAX_TORQUE;
      r.rd_st               = PST_RD_IDLE;
      r.drive.loop          = PST_LOOP_OTHER;
      return r;
   endfunction : pst_state_rst

   // Port a follows the contacts, port b serves bus reads; two ports keep
   // a register read from ever disturbing the speed reference
   pst_speed_mem #(
      .W     (16),
      .DEPTH (8)
   ) u_speed_mem (
      .i_clock     (i_clock),
      .i_sys_rst   (i_sys_rst),
      .i_wr_en     (mem_we),
      .i_wr_addr   (mem_waddr),
      .i_wr_data   (mem_wdata),
      .i_rd_addr_a (idx_now),
      .o_rd_data_a (spd_a),
      .i_rd_addr_b (rd_b_addr),
      .o_rd_data_b (spd_b)
   );

   assign idx_now = pst_index(i_contact);
   assign mode    = s_r.control_mode_select[`PST_MODE_MSB:`PST_MODE_LSB];
   assign raw     = (s_r.rd_st == PST_RD_IDLE) ? i_axi.araddr : s_r.rd_addr;
   assign rd_b_addr = raw[4:2];

   always_comb begin
      s_nxt     = s_r;
      mem_we    = 1'b0;
      mem_waddr = '0;
      mem_wdata = '0;
      waw       = {s_r.aw_addr[7:2], 2'b00};
      wold      = '0;
      wok       = 1'b1;

      // Write channel: address and data taken in either order
      if (i_axi.awvalid && !s_r.aw_have && !s_r.bvalid) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.aw_addr = i_axi.awaddr;
      end
      if (i_axi.wvalid && !s_r.w_have && !s_r.bvalid) begin
         s_nxt.w_have = 1'b1;
         s_nxt.w_data = i_axi.wdata;
         s_nxt.w_strb = i_axi.wstrb;
      end
      case (waw)
         `PST_OFS_CTRL:    wold = {s_r.function_option_select, s_r.control_mode_select};
         `PST_OFS_FWD_INT: wold = {22'h0, s_r.fwd_int};
         `PST_OFS_REV_INT: wold = {22'h0, s_r.rev_int};
         `PST_OFS_FWD_EXT: wold = {22'h0, s_r.fwd_ext};
         `PST_OFS_REV_EXT: wold = {22'h0, s_r.rev_ext};
         `PST_OFS_MOT_SPD: wold = {16'h0, s_r.mot_spd};
         `PST_OFS_MOT_TRQ: wold = {22'h0, s_r.mot_trq};
         default:          wold = '0;
      endcase
      wnew = pst_merge(wold, s_r.w_data, s_r.w_strb);
      if (s_r.aw_have && s_r.w_have) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         case (waw)
            `PST_OFS_CTRL: begin
               s_nxt.control_mode_select    = wnew[15:0];
               s_nxt.function_option_select = wnew[31:16];
            end
            `PST_OFS_FWD_INT: s_nxt.fwd_int = pst_sat10(wnew[15:0], `PST_MAX_INT_TRQ);
            `PST_OFS_REV_INT: s_nxt.rev_int = pst_sat10(wnew[15:0], `PST_MAX_INT_TRQ);
            `PST_OFS_FWD_EXT: s_nxt.fwd_ext = pst_sat10(wnew[15:0], `PST_MAX_EXT_TRQ);
            `PST_OFS_REV_EXT: s_nxt.rev_ext = pst_sat10(wnew[15:0], `PST_MAX_EXT_TRQ);
            `PST_OFS_MOT_SPD: s_nxt.mot_spd = wnew[15:0];
            `PST_OFS_MOT_TRQ: s_nxt.mot_trq = wnew[9:0];
            default: begin
               // Partial strobes on a preset are dropped: half a speed word means nothing
               if (waw >= `PST_OFS_SPD1 && waw <= `PST_OFS_SPD7) begin
                  // Preset store, clamped to the setting range
                  mem_we    = (s_r.w_strb[1:0] == 2'b11);
                  mem_waddr = waw[4:2];
                  mem_wdata = pst_clamp_spd(s_r.w_data[15:0], `PST_MAX_SET_SPD);
               end else begin
                  wok = 1'b0;
               end
            end
         endcase
         s_nxt.bresp = wok ? `PST_RESP_OKAY : `PST_RESP_SLVERR;
      end
      if (s_r.bvalid && i_axi.bready) begin
         s_nxt.bvalid = 1'b0;
      end

      // The fetch cycle gives the table word time to reach its output register
      // Read channel: one cycle to fetch table data, then the answer
      case (s_r.rd_st)
         PST_RD_IDLE: begin
            if (i_axi.arvalid) begin
               s_nxt.rd_addr = i_axi.araddr;
               s_nxt.rd_st   = PST_RD_FETCH;
            end
         end
         PST_RD_FETCH: begin
            s_nxt.rresp = `PST_RESP_OKAY;
            case ({s_r.rd_addr[7:2], 2'b00})
               `PST_OFS_CTRL:    s_nxt.rdata = {s_r.function_option_select, s_r.control_mode_select};
               `PST_OFS_FWD_INT: s_nxt.rdata = {22'h0, s_r.fwd_int};
               `PST_OFS_REV_INT: s_nxt.rdata = {22'h0, s_r.rev_int};
               `PST_OFS_FWD_EXT: s_nxt.rdata = {22'h0, s_r.fwd_ext};
               `PST_OFS_REV_EXT: s_nxt.rdata = {22'h0, s_r.rev_ext};
               `PST_OFS_MOT_SPD: s_nxt.rdata = {16'h0, s_r.mot_spd};
               `PST_OFS_MOT_TRQ: s_nxt.rdata = {22'h0, s_r.mot_trq};
               `PST_OFS_STATUS:  s_nxt.rdata = {23'h0, s_r.drive.analog_limit_used, 1'b0,
                                                s_r.idx, 1'b0, s_r.drive.preset_active,
                                                s_r.drive.loop};
               `PST_OFS_SPD_OUT: s_nxt.rdata = {{16{s_r.drive.speed_ref[15]}}, s_r.drive.speed_ref};
               `PST_OFS_TRQ_OUT: s_nxt.rdata = {6'h0, s_r.drive.rev_torque_limit,
                                                6'h0, s_r.drive.fwd_torque_limit};
               default: begin
                  if (s_r.rd_addr >= `PST_OFS_SPD1 && s_r.rd_addr <= `PST_OFS_SPD7 + 8'h03) begin
                     s_nxt.rdata = {{16{spd_b[15]}}, spd_b};
                  end else begin
                     s_nxt.rdata = '0;
                     s_nxt.rresp = `PST_RESP_SLVERR;
                  end
               end
            endcase
            s_nxt.rd_st = PST_RD_RESP;
         end
         PST_RD_RESP: begin
            if (i_axi.rready) begin
               s_nxt.rd_st = PST_RD_IDLE;
            end
         end
         default: s_nxt.rd_st = PST_RD_IDLE;
      endcase

      // Index lines up with the table word read this cycle
      s_nxt.idx = idx_now;
      s_nxt.drive.preset_active = 1'b0;
      s_nxt.drive.speed_ref     = '0;
      s_nxt.drive.loop          = PST_LOOP_OTHER;
      case (mode)
         // Index zero reads a zero word
         `PST_MODE_PRESET: begin
            s_nxt.drive.loop          = PST_LOOP_SPEED;
            s_nxt.drive.preset_active = 1'b1;
         end
         // Nonzero index keeps presets, index zero hands over
         `PST_MODE_SW_SPEED: begin
            s_nxt.drive.loop          = PST_LOOP_SPEED;
            s_nxt.drive.preset_active = (s_r.idx != 3'h0);
         end
         // Hand over to pulse train position control
         `PST_MODE_SW_POS: begin
            s_nxt.drive.loop          = (s_r.idx != 3'h0) ? PST_LOOP_SPEED : PST_LOOP_POS;
            s_nxt.drive.preset_active = (s_r.idx != 3'h0);
         end
         `PST_MODE_SW_TRQ: begin
            s_nxt.drive.loop          = (s_r.idx != 3'h0) ? PST_LOOP_SPEED : PST_LOOP_TRQ;
            s_nxt.drive.preset_active = (s_r.idx != 3'h0);
         end
         default: s_nxt.drive.loop = PST_LOOP_OTHER;
      endcase
      if (s_nxt.drive.preset_active) begin
         s_nxt.drive.speed_ref = signed'(pst_clamp_spd(spd_a, s_r.mot_spd));
      end

      // Contacts pick speeds in modes 3 to 6, so external limits stay off there
      ext_ok = !(mode >= `PST_MODE_PRESET && mode <= `PST_MODE_SW_TRQ);
      // Function option digit enables analog limit
      // Not while the torque loop is in charge
      ana_en = (s_r.function_option_select[`PST_ATL_MSB:`PST_ATL_LSB] == `PST_ATL_ON) &&
               (s_nxt.drive.loop != PST_LOOP_TRQ) &&
               !((s_nxt.drive.loop == PST_LOOP_OTHER) && i_torque_control_active);
      // Full scale negative input saturates rather than wrapping to a small limit
      // Magnitude only
      ana_abs = pst_sat10(i_analog_torque_limit[15] ? 16'(-i_analog_torque_limit)
                                                    : i_analog_torque_limit, 10'h3FF);
      fwd_lim = s_r.fwd_int;
      rev_lim = s_r.rev_int;
      if (ext_ok && (s_r.idx[1])) begin
         fwd_lim = pst_min10(fwd_lim, s_r.fwd_ext);
      end
      if (ext_ok && (s_r.idx[0])) begin
         rev_lim = pst_min10(rev_lim, s_r.rev_ext);
      end
      if (ana_en) begin
         fwd_lim = pst_min10(fwd_lim, ana_abs);
         rev_lim = pst_min10(rev_lim, ana_abs);
      end
      s_nxt.drive.fwd_torque_limit  = pst_min10(fwd_lim, s_r.mot_trq);
      s_nxt.drive.rev_torque_limit  = pst_min10(rev_lim, s_r.mot_trq);
      s_nxt.drive.analog_limit_used = ana_en;
   end

   // Synchronous reset; the drive outputs fall back to the idle loop code
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         s_r <= pst_state_rst();
      end else begin
         s_r <= s_nxt;
      end
   end

   // Ready terms are combinational; the held beat blocks a second one
   always_comb begin
      o_axi.awready = !s_r.aw_have && !s_r.bvalid;
      o_axi.wready  = !s_r.w_have && !s_r.bvalid;
      o_axi.bvalid  = s_r.bvalid;
      o_axi.bresp   = s_r.bresp;
      o_axi.arready = (s_r.rd_st == PST_RD_IDLE);
      o_axi.rvalid  = (s_r.rd_st == PST_RD_RESP);
      o_axi.rdata   = s_r.rdata;
      o_axi.rresp   = s_r.rresp;
   end

   assign o_drive = s_r.drive;
endmodule : pst_top

// ### tb/preset_speed_and_torque_limit_select_bench.sv
// Self-checking bench of the preset speed and torque limit block
module preset_speed_and_torque_limit_select_bench;
   import pst_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic               i_clock;
   logic               i_sys_rst;
   pst_axi_req_t       req;
   pst_axi_rsp_t       rsp;
   pst_contact_t       contact;
   logic signed [15:0] analog;
   logic               trq_act;
   pst_drive_t         drv;
   logic [2:0]         sel;
   int                 bad_count = 0;
   int                 checks = 0;
   int                 cyc = 0;
   logic [31:0]        rv [13] = '{32'h0000_0064, 32'h0000_00C8, 32'h0000_012C, 32'hFFFF_FF9C, 32'hFFFF_FF38,
      32'hFFFF_FED4, 32'h0000_01F4, 32'h0000_012C, 32'h0000_012C, 32'h0000_0064, 32'h0000_0064,
      32'h0000_1770, 32'h0000_012C};
   pst_loop_t          lps [3] = '{PST_LOOP_SPEED, PST_LOOP_POS, PST_LOOP_TRQ};

   pst_top i_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_axi(req), .o_axi(rsp), .i_contact(contact),
      .i_analog_torque_limit(analog), .i_torque_control_active(trq_act), .o_drive(drv));
   pst_host_model i_host (.i_clock(i_clock), .i_index(sel), .o_contact(contact));

   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end

   // A hang counts as a failure
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         close_out();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      req.awaddr  <= a;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      // Ready follows valid by one cycle so the held response is exercised
      do begin
         @(posedge i_clock);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid && !req.bready) req.bready <= 1'b1;
      end while (!(rsp.bvalid === 1'b1 && req.bready === 1'b1));
      req.bready <= 1'b0;
      chk(rsp.bresp, er);
      @(posedge i_clock);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      req.araddr  <= a;
      req.arvalid <= 1'b1;
      do begin
         @(posedge i_clock);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid && !req.rready) req.rready <= 1'b1;
      end while (!(rsp.rvalid === 1'b1 && req.rready === 1'b1));
      req.rready <= 1'b0;
      chk({rsp.rresp, rsp.rdata}, {er, ed});
      @(posedge i_clock);
   endtask : rd

   // Contacts pass the host model, then two stages inside
   task automatic see(input logic [2:0] s, input pst_loop_t lp, input logic pa, input logic [15:0] sp,
                      input logic [9:0] fl, input logic [9:0] rl, input logic an);
      sel <= s;
      repeat (4) @(posedge i_clock);
      chk(drv, {lp, pa, sp, fl, rl, an});
   endtask : see

   task automatic close_out();
      if (bad_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   initial begin
      i_sys_rst = 1'b1;
      req       = '0;
      sel       = 3'h0;
      analog    = 16'hFFCE;
      trq_act   = 1'b0;
      repeat (16) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      @(posedge i_clock);
      for (int i = 0; i < 13; i++) rd(8'h04 + 8'(4 * i), rv[i], 2'h0);
      rd(8'h44, 32'h0000_0000, 2'h2);
      wr(8'h38, 32'h0000_0001, 2'h2);
      wr(8'h04, 32'h0000_1B58, 2'h0);
      rd(8'h04, 32'h0000_1770, 2'h0);
      wr(8'h04, 32'h0000_0064, 2'h0);
      wr(8'h00, 32'h0000_0030, 2'h0);
      // Preset mode keeps the preset path on at index zero, whose word reads zero
      for (int i = 0; i < 8; i++) see(3'(i), PST_LOOP_SPEED, 1'b1, rv[(i + 6) % 7][15:0] & {16{i != 0}},
         10'h12C, 10'h12C, 1'b0);
      wr(8'h30, 32'h0000_00FA, 2'h0);
      see(3'h3, PST_LOOP_SPEED, 1'b1, 16'h00FA, 10'h12C, 10'h12C, 1'b0);
      see(3'h6, PST_LOOP_SPEED, 1'b1, 16'hFF06, 10'h12C, 10'h12C, 1'b0);
      wr(8'h30, 32'h0000_1770, 2'h0);
      for (int m = 4; m < 7; m++) begin
         wr(8'h00, 32'(m) << 4, 2'h0);
         see(3'h0, lps[m - 4], 1'b0, 16'h0000, 10'h12C, 10'h12C, 1'b0);
         see(3'h4, PST_LOOP_SPEED, 1'b1, 16'hFF9C, 10'h12C, 10'h12C, 1'b0);
      end
      wr(8'h00, 32'h0000_0000, 2'h0);
      wr(8'h20, 32'h0000_01C2, 2'h0);
      rd(8'h20, 32'h0000_0190, 2'h0);
      see(3'h0, PST_LOOP_OTHER, 1'b0, 16'h0000, 10'h12C, 10'h12C, 1'b0);
      wr(8'h20, 32'h0000_00FA, 2'h0);
      see(3'h2, PST_LOOP_OTHER, 1'b0, 16'h0000, 10'h064, 10'h12C, 1'b0);
      see(3'h1, PST_LOOP_OTHER, 1'b0, 16'h0000, 10'h0FA, 10'h064, 1'b0);
      wr(8'h00, 32'h0100_0000, 2'h0);
      see(3'h0, PST_LOOP_OTHER, 1'b0, 16'h0000, 10'h032, 10'h032, 1'b1);
      trq_act <= 1'b1;
      see(3'h0, PST_LOOP_OTHER, 1'b0, 16'h0000, 10'h0FA, 10'h12C, 1'b0);
      wr(8'h00, 32'h0100_0060, 2'h0);
      see(3'h0, PST_LOOP_TRQ, 1'b0, 16'h0000, 10'h0FA, 10'h12C, 1'b0);
      wr(8'h00, 32'h0100_0050, 2'h0);
      see(3'h0, PST_LOOP_POS, 1'b0, 16'h0000, 10'h032, 10'h032, 1'b1);
      close_out();
   end
endmodule : preset_speed_and_torque_limit_select_bench

// ### tb/pst_host_model.sv
// Host controller model driving the three contact inputs
module pst_host_model
   import pst_pkg::*;
(
   // Clock
   input  wire logic       i_clock,
   // Speed index wanted by the bench
   input  wire logic [2:0] i_index,
   // Contacts, active low
   output pst_contact_t    o_contact
);
   timeunit 1ns;
   timeprecision 1ns;
   initial o_contact = 3'b111;
   // low is on; outside modes 3 to 6 the forward and reverse terminals also select the external torque limits
   always @(posedge i_clock) begin
      o_contact <= ~i_index;
   end
endmodule : pst_host_model

// ### tb/pst_top_checker.sv
// Port-level checks of the preset speed and torque limit block
module pst_top_checker
   import pst_pkg::*;
#(
   parameter logic [15:0] MOTOR_MAX_SPEED  = 16'h1770,
   parameter logic [9:0]  MOTOR_MAX_TORQUE = 10'h12C
) (
   // Clock and reset
   input wire logic               i_clock,
   input wire logic               i_sys_rst,
   // Watched ports
   input wire pst_axi_req_t       i_axi,
   input wire pst_axi_rsp_t       o_axi,
   input wire pst_contact_t       i_contact,
   input wire logic signed [15:0] i_analog_torque_limit,
   input wire logic               i_torque_control_active,
   input wire pst_drive_t         o_drive
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   wire signed [16:0] spd_ref = {o_drive.speed_ref[15], o_drive.speed_ref};
   wire signed [16:0] spd_max = {1'b0, MOTOR_MAX_SPEED};
   property p_zero_ref;
      !o_drive.preset_active |-> o_drive.speed_ref == 16'h0000;
   endproperty
   a_zero_ref: assert property (p_zero_ref) else $error("speed nonzero without preset");
   property p_spd_cap;
      o_drive.preset_active |-> spd_ref <= spd_max && spd_ref >= -spd_max;
   endproperty
   a_spd_cap: assert property (p_spd_cap) else $error("speed above motor maximum");
   property p_trq_cap;
      o_drive.fwd_torque_limit <= MOTOR_MAX_TORQUE && o_drive.rev_torque_limit <= MOTOR_MAX_TORQUE;
   endproperty
   a_trq_cap: assert property (p_trq_cap) else $error("torque limit above motor maximum");
   // Index zero held two samples gives a zero reference in every mode
   property p_idx0;
      i_contact == 3'b111 ##1 i_contact == 3'b111 |=> o_drive.speed_ref == 16'h0000;
   endproperty
   a_idx0: assert property (p_idx0) else $error("speed with all contacts off");
   property p_preset_loop;
      o_drive.preset_active |-> o_drive.loop == PST_LOOP_SPEED;
   endproperty
   a_preset_loop: assert property (p_preset_loop) else $error("preset outside speed loop");
   property p_trq_no_analog;
      o_drive.loop == PST_LOOP_TRQ |-> !o_drive.analog_limit_used;
   endproperty
   a_trq_no_analog: assert property (p_trq_no_analog) else $error("analog limit in torque loop");
   property p_b_hold;
      o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_rst_out;
      disable iff (1'b0) i_sys_rst |=> o_drive.loop == PST_LOOP_OTHER && !o_drive.preset_active;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("drive not idle after reset");
   c_preset: cover property (o_drive.preset_active);
   c_pos: cover property (o_drive.loop == PST_LOOP_POS);
   c_analog: cover property (o_drive.analog_limit_used);
endmodule : pst_top_checker

bind pst_top pst_top_checker #(.MOTOR_MAX_SPEED(MOTOR_MAX_SPEED), .MOTOR_MAX_TORQUE(MOTOR_MAX_TORQUE)) i_chk (
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_axi(i_axi), .o_axi(o_axi), .i_contact(i_contact),
   .i_analog_torque_limit(i_analog_torque_limit), .i_torque_control_active(i_torque_control_active),
   .o_drive(o_drive));
